// ===== design/ttf_cfg.svh
`ifndef TTF_CFG_SVH
`define TTF_CFG_SVH
// register byte addresses on the 16-bit register port
`define TTF_ADDR_OFS_HIGH 16'hFE16
`define TTF_ADDR_OFS_LOW 16'hFE17
`define TTF_ADDR_GAIN 16'hFE18
`define TTF_ADDR_THRESH 16'hFE19
// field positions
`define TTF_OFS_MSB_BIT 0
`define TTF_OFS_POL_BIT 1
`define TTF_GAIN_POL_BIT 7
`define TTF_GAIN_MAG_HI 6
// reset values
`define TTF_RST_REG 8'h00
`define TTF_RST_THRESH 8'h03
// debounce time in microseconds and clock rate
`define TTF_DEBOUNCE_US 100000
`define TTF_CLK_MHZ 200
`define TTF_DEBOUNCE_CYC (`TTF_DEBOUNCE_US * `TTF_CLK_MHZ)
`endif

// ===== design/ttf_pkg.sv
package ttf_pkg;
	// debounce state of the fault flag
	typedef enum logic [2:0] {
		TTF_IDLE = 3'b001,
		TTF_COUNT = 3'b010,
		TTF_FAULT = 3'b100
	} ttf_state_t;
endpackage : ttf_pkg

// ===== design/ttf_debounce.sv
`timescale 1ns/1ps
`include "ttf_cfg.svh"
// holds a level for a programmable number of cycles before reporting it
module ttf_debounce
	import ttf_pkg::*;
#(
	parameter int CNT_W = 25
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic cond_in,
	input wire logic [CNT_W-1:0] limit_in,
	output logic flag_out
);
	ttf_state_t state;
	ttf_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;

	// ------------------------------------------------------------
	// debounce machine
	// ------------------------------------------------------------
	// any drop of the condition restarts the interval from zero
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			TTF_IDLE: begin
				next_cnt = '0;
				if (cond_in) begin
					next_state = TTF_COUNT;
					next_cnt = CNT_W'(1);
				end
			end
			TTF_COUNT: begin
				if (!cond_in) begin
					next_state = TTF_IDLE;
					next_cnt = '0;
				end else if (cnt >= limit_in) begin
					next_state = TTF_FAULT;
				end else begin
					next_cnt = cnt + CNT_W'(1);
				end
			end
			TTF_FAULT: begin
				if (!cond_in) begin
					next_state = TTF_IDLE;
					next_cnt = '0;
				end
			end
			default: begin
				next_state = TTF_IDLE;
				next_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state <= TTF_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	assign flag_out = (state == TTF_FAULT);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_restart;
		@(posedge clk_sys_in) disable iff (rst_in)
		!cond_in |=> !flag_out && cnt == '0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("debounce did not restart");

	property p_no_early;
		@(posedge clk_sys_in) disable iff (rst_in)
		$rose(flag_out) |-> $past(cnt) >= limit_in && $past(cond_in);
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("fault flag before debounce end");

	c_fault: cover property (@(posedge clk_sys_in) $rose(flag_out));
	c_abort: cover property (@(posedge clk_sys_in)
		state == TTF_COUNT && !cond_in);
endmodule : ttf_debounce

// ===== design/ttf_temp_trim.sv
`timescale 1ns/1ps
`include "ttf_cfg.svh"
// Overview of operation
// - trim writes ignored until unlocked
// - nine-bit offset: high bit0 plus low byte
// - polarity bit1 set subtracts offset, else adds
// - gain bit7 set gives negative gain trim
// - gain magnitude bits 6..0 scale gain
// - zero-extended threshold versus nine reading MSBs
// - fault when reading below threshold
// - fault debounced for 100 ms
// - one threshold count is 3.125 mV
module ttf_temp_trim
	import ttf_pkg::*;
#(
	parameter int ADC_W = 12,
	parameter int DEBOUNCE_CYC = `TTF_DEBOUNCE_CYC,
	parameter int CNT_W = 25
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic trim_unlock_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic adc_valid_in,
	input wire logic [ADC_W-1:0] adc_data_in,
	output logic [ADC_W-1:0] temp_trimmed_out,
	output logic temp_valid_out,
	output logic overtemp_fault_out
);
	localparam int SUM_W = ADC_W + 9;

	logic [7:0] temp_offset_trim_high;
	logic [7:0] temp_offset_trim_low;
	logic [7:0] temp_gain_trim;
	logic [7:0] overtemp_fault_threshold;
	logic [7:0] next_ofs_high;
	logic [7:0] next_ofs_low;
	logic [7:0] next_gain;
	logic [7:0] next_thresh;
	logic [7:0] next_rdata;
	logic [ADC_W-1:0] next_trimmed;
	logic next_valid;
	logic below_thresh;
	logic [8:0] thresh9;

	// saturate a signed intermediate into the unsigned reading range
	function automatic logic [ADC_W-1:0] clamp(input logic signed [SUM_W:0] v);
		if (v < 0)
			clamp = '0;
		else if (v > $signed({{(SUM_W-ADC_W+1){1'b0}}, {ADC_W{1'b1}}}))
			clamp = '1;
		else
			clamp = v[ADC_W-1:0];
	endfunction : clamp

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	// trims only move while unlocked; threshold is always writable
	always_comb begin
		next_ofs_high = temp_offset_trim_high;
		next_ofs_low = temp_offset_trim_low;
		next_gain = temp_gain_trim;
		next_thresh = overtemp_fault_threshold;
		if (reg_wr_in) begin
			case (reg_addr_in)
				`TTF_ADDR_OFS_HIGH: if (trim_unlock_in)
					next_ofs_high = reg_wdata_in;
				`TTF_ADDR_OFS_LOW: if (trim_unlock_in)
					next_ofs_low = reg_wdata_in;
				`TTF_ADDR_GAIN: if (trim_unlock_in)
					next_gain = reg_wdata_in;
				`TTF_ADDR_THRESH: next_thresh = reg_wdata_in;
				default: begin
				end
			endcase
		end
		// reads return register contents; unmapped addresses read zero
		case (reg_addr_in)
			`TTF_ADDR_OFS_HIGH: next_rdata = temp_offset_trim_high;
			`TTF_ADDR_OFS_LOW: next_rdata = temp_offset_trim_low;
			`TTF_ADDR_GAIN: next_rdata = temp_gain_trim;
			`TTF_ADDR_THRESH: next_rdata = overtemp_fault_threshold;
			default: next_rdata = 8'h00;
		endcase
		if (!reg_rd_in)
			next_rdata = reg_rdata_out;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			temp_offset_trim_high <= `TTF_RST_REG;
			temp_offset_trim_low <= `TTF_RST_REG;
			temp_gain_trim <= `TTF_RST_REG;
			overtemp_fault_threshold <= `TTF_RST_THRESH;
			reg_rdata_out <= 8'h00;
		end else begin
			temp_offset_trim_high <= next_ofs_high;
			temp_offset_trim_low <= next_ofs_low;
			temp_gain_trim <= next_gain;
			overtemp_fault_threshold <= next_thresh;
			reg_rdata_out <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// trim datapath
	// ------------------------------------------------------------
	// gain step is 1/1024 per count; sign-magnitude, then offset.
	// one register stage keeps it short; result saturates, no wrap.
	always_comb begin
		logic signed [SUM_W:0] rd;
		logic signed [SUM_W:0] gadj;
		logic signed [SUM_W:0] ofs;
		gadj = '0;
		ofs = '0;
		rd = $signed({{(SUM_W-ADC_W+1){1'b0}}, adc_data_in});
		gadj = (rd * $signed({1'b0, temp_gain_trim[`TTF_GAIN_MAG_HI:0]}))
			>>> 10;
		if (temp_gain_trim[`TTF_GAIN_POL_BIT])
			rd = rd - gadj;
		else
			rd = rd + gadj;
		ofs = $signed({{(SUM_W-8){1'b0}},
			temp_offset_trim_high[`TTF_OFS_MSB_BIT],
			temp_offset_trim_low});
		if (temp_offset_trim_high[`TTF_OFS_POL_BIT])
			rd = rd - ofs;
		else
			rd = rd + ofs;
		next_trimmed = adc_valid_in ? clamp(rd) : temp_trimmed_out;
		next_valid = adc_valid_in;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			temp_trimmed_out <= '0;
			temp_valid_out <= 1'b0;
		end else begin
			temp_trimmed_out <= next_trimmed;
			temp_valid_out <= next_valid;
		end
	end

	// ------------------------------------------------------------
	// fault compare and debounce
	// ------------------------------------------------------------
	// one threshold count is 3.125 mV of sensor voltage; codes
	// outside 0x03..0xFA are software's to avoid, not checked here
	assign thresh9 = {1'b0, overtemp_fault_threshold};
	assign below_thresh =
		temp_trimmed_out[ADC_W-1:ADC_W-9] < thresh9;

	ttf_debounce #(
		.CNT_W(CNT_W)
	) u_debounce (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.cond_in(below_thresh),
		.limit_in(CNT_W'(DEBOUNCE_CYC - 1)),
		.flag_out(overtemp_fault_out)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_locked;
		@(posedge clk_sys_in) disable iff (rst_in)
		reg_wr_in && !trim_unlock_in && reg_addr_in == `TTF_ADDR_GAIN
		|=> $stable(temp_gain_trim);
	endproperty
	a_locked: assert property (p_locked)
		else $error("gain trim changed while locked");

	property p_unlocked;
		@(posedge clk_sys_in) disable iff (rst_in)
		reg_wr_in && trim_unlock_in && reg_addr_in == `TTF_ADDR_OFS_LOW
		|=> temp_offset_trim_low == $past(reg_wdata_in);
	endproperty
	a_unlocked: assert property (p_unlocked)
		else $error("offset low write lost");

	property p_zero_trim;
		@(posedge clk_sys_in) disable iff (rst_in)
		adc_valid_in && temp_gain_trim[6:0] == 7'h00 &&
		temp_offset_trim_low == 8'h00 &&
		temp_offset_trim_high[0] == 1'b0
		|=> temp_trimmed_out == $past(adc_data_in);
	endproperty
	a_zero_trim: assert property (p_zero_trim)
		else $error("zero trim altered the reading");

	property p_sub;
		@(posedge clk_sys_in) disable iff (rst_in)
		adc_valid_in && temp_gain_trim[6:0] == 7'h00 &&
		temp_offset_trim_high[1:0] == 2'b10 &&
		adc_data_in >= ADC_W'(temp_offset_trim_low)
		|=> temp_trimmed_out ==
			$past(adc_data_in) - ADC_W'($past(temp_offset_trim_low));
	endproperty
	a_sub: assert property (p_sub)
		else $error("negative offset not subtracted");

	property p_neg_gain;
		@(posedge clk_sys_in) disable iff (rst_in)
		adc_valid_in && temp_gain_trim[7] &&
		temp_offset_trim_low == 8'h00 && temp_offset_trim_high[0] == 1'b0
		|=> temp_trimmed_out <= $past(adc_data_in);
	endproperty
	a_neg_gain: assert property (p_neg_gain)
		else $error("negative gain raised the reading");

	property p_compare;
		@(posedge clk_sys_in) disable iff (rst_in)
		// whole-reading form, so the check does not reuse the slice
		below_thresh == (int'(temp_trimmed_out) <
			(int'(overtemp_fault_threshold) << (ADC_W - 9)));
	endproperty
	a_compare: assert property (p_compare)
		else $error("threshold compare wrong");

	property p_fault_cause;
		@(posedge clk_sys_in) disable iff (rst_in)
		overtemp_fault_out |-> $past(below_thresh);
	endproperty
	a_fault_cause: assert property (p_fault_cause)
		else $error("fault without low reading");

	c_unlock_wr: cover property (@(posedge clk_sys_in)
		reg_wr_in && trim_unlock_in);
	c_below: cover property (@(posedge clk_sys_in) $rose(below_thresh));
	c_fault_top: cover property (@(posedge clk_sys_in)
		$fell(overtemp_fault_out));
endmodule : ttf_temp_trim

// ===== tb/ttf_adc_model.sv
`timescale 1ns/1ps
// stands in for the sensor converter: one-cycle sample pulses
module ttf_adc_model (
	input wire logic clk_sys_in,
	input wire logic go_in,
	input wire logic [11:0] code_in,
	output logic valid_out,
	output logic [11:0] data_out
);
	// start quiet so the block never sees an unknown pulse
	initial begin
		valid_out = 1'b0;
		data_out = 12'h000;
	end
	// data means nothing without the pulse, so it is scrambled between
	always @(posedge clk_sys_in) begin
		valid_out <= go_in;
		data_out <= go_in ? code_in : ~data_out;
	end
endmodule : ttf_adc_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "ttf_cfg.svh"
module tb_top;
	import ttf_pkg::*;
	// short debounce keeps the run small
	localparam int DEB = 20;
	logic clk_sys_in, rst_in, trim_unlock_in, reg_wr_in, reg_rd_in, go;
	logic [15:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out;
	logic adc_valid_in, temp_valid_out, overtemp_fault_out;
	logic [11:0] adc_data_in, code, temp_trimmed_out;
	int n_errors, comparisons, seed, exp_r;
	int m_reg [4];
	ttf_temp_trim #(.DEBOUNCE_CYC(DEB)) ttf_temp_trim_i (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.trim_unlock_in(trim_unlock_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.adc_valid_in(adc_valid_in), .adc_data_in(adc_data_in),
		.temp_trimmed_out(temp_trimmed_out),
		.temp_valid_out(temp_valid_out),
		.overtemp_fault_out(overtemp_fault_out));
	ttf_adc_model ttf_adc_model_i (.clk_sys_in(clk_sys_in), .go_in(go),
		.code_in(code), .valid_out(adc_valid_in), .data_out(adc_data_in));
	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task automatic chk(input logic [15:0] got, input int e);
		comparisons++;
		if (got !== 16'(e)) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, 16'(e));
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
		// trims only change while unlocked
		if (trim_unlock_in || a == `TTF_ADDR_THRESH) begin
			m_reg[a - `TTF_ADDR_OFS_HIGH] = d;
		end
	endtask : wr
	task automatic rd(input logic [15:0] a, input int e);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1;
		chk(reg_rdata_out, e);
	endtask : rd
	task automatic smp(input logic [11:0] d);
		int adj, r, o;
		adj = (int'(d) * (m_reg[2] & 127)) >>> 10;
		r = m_reg[2][7] ? int'(d) - adj : int'(d) + adj;
		o = (m_reg[0] & 1) * 256 + m_reg[1];
		r = m_reg[0][1] ? r - o : r + o;
		exp_r = r < 0 ? 0 : (r > 4095 ? 4095 : r);
		@(posedge clk_sys_in);
		go <= 1'b1;
		code <= d;
		@(posedge clk_sys_in);
		go <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		chk(temp_valid_out, 1);
		chk(temp_trimmed_out, exp_r);
	endtask : smp
	// counts edges from a below-threshold sample to the flag
	task automatic fault_run(input logic [11:0] d);
		int n;
		smp(d);
		n = 0;
		// look after the edge has settled, never in its own time step
		while (overtemp_fault_out !== 1'b1 && n < 3 * DEB) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		// the condition is sampled DEB times before the flag shows
		chk(16'(n), DEB);
		if (n >= 3 * DEB) begin
			stop_test();
		end
	endtask : fault_run
	task automatic stop_test;
		if (n_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	// free-running system clock
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	// main sequence
	initial begin
		{rst_in, trim_unlock_in, reg_wr_in, reg_rd_in, go} = 5'h10;
		reg_addr_in = 16'h0000;
		reg_wdata_in = 8'h00;
		code = 12'h000;
		n_errors = 0;
		comparisons = 0;
		seed = 32'h1b09e0a1;
		m_reg = '{0, 0, 0, 3};
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		// reset values, then one unmapped place
		for (int i = 0; i < 5; i++) begin
			rd(`TTF_ADDR_OFS_HIGH + 16'(i),
				m_reg[i % 4] & {8{i < 4}});
		end
		// locked: only the threshold takes the write
		for (int i = 0; i < 4; i++) begin
			wr(`TTF_ADDR_OFS_HIGH + 16'(i), 8'hA5);
		end
		for (int i = 0; i < 4; i++) begin
			rd(`TTF_ADDR_OFS_HIGH + 16'(i), m_reg[i]);
		end
		@(posedge clk_sys_in);
		trim_unlock_in <= 1'b1;
		// random trims on the three trim registers
		for (int i = 0; i < 30; i++) begin
			wr(`TTF_ADDR_OFS_HIGH + 16'(i % 3), 8'($random(seed)));
			smp(12'($random(seed)));
		end
		rd(`TTF_ADDR_GAIN, m_reg[2]);
		// clamp at both ends of the range
		wr(`TTF_ADDR_GAIN, 8'h00);
		wr(`TTF_ADDR_OFS_LOW, 8'hFF);
		wr(`TTF_ADDR_OFS_HIGH, 8'h03);
		smp(12'h050);
		wr(`TTF_ADDR_OFS_HIGH, 8'h01);
		smp(12'hF80);
		// plain subtraction, then the largest negative gain alone
		wr(`TTF_ADDR_OFS_HIGH, 8'h02);
		wr(`TTF_ADDR_OFS_LOW, 8'h10);
		smp(12'h100);
		wr(`TTF_ADDR_OFS_HIGH, 8'h00);
		wr(`TTF_ADDR_OFS_LOW, 8'h00);
		wr(`TTF_ADDR_GAIN, 8'hFF);
		smp(12'h800);
		wr(`TTF_ADDR_GAIN, 8'h00);
		wr(`TTF_ADDR_THRESH, 8'h80);
		// equal to the threshold is not a fault
		smp(12'h400);
		repeat (DEB + 4) @(posedge clk_sys_in);
		chk(overtemp_fault_out, 0);
		smp(12'h3F8);
		repeat (DEB / 2) @(posedge clk_sys_in);
		smp(12'h400);
		chk(overtemp_fault_out, 0);
		fault_run(12'h3F8);
		chk(overtemp_fault_out, 1);
		smp(12'hFFF);
		@(posedge clk_sys_in);
		#1;
		chk(overtemp_fault_out, 0);
		// mid-run reset returns every register to its reset value
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		m_reg = '{0, 0, 0, 3};
		#1;
		chk(temp_valid_out, 0);
		chk(temp_trimmed_out, 0);
		chk(overtemp_fault_out, 0);
		for (int i = 0; i < 4; i++) begin
			rd(`TTF_ADDR_OFS_HIGH + 16'(i), m_reg[i]);
		end
		stop_test();
	end
endmodule : tb_top
